// ==== rtl/ipde_regs.vh ====
// Purpose: constants for the idle power-down and engine drive block
// Assumes: 50 MHz clock, 20 ns period
// Notes: timeout selection codes and timing counts
`ifndef IPDE_REGS_VH
`define IPDE_REGS_VH
`define IPDE_CLK_HZ 50000000
`define IPDE_TO_15M 3'h0
`define IPDE_TO_30M 3'h1
`define IPDE_TO_1H 3'h2
`define IPDE_TO_2H 3'h3
`define IPDE_TO_3H 3'h4
`define IPDE_TO_DEFAULT 3'h2
`define IPDE_SEC_PER_MIN 60
`define IPDE_MINUTES_15 40'h0F
`define IPDE_MINUTES_30 40'h1E
`define IPDE_MINUTES_60 40'h3C
`define IPDE_MINUTES_120 40'h78
`define IPDE_MINUTES_180 40'hB4
`define IPDE_TRAY_2 2'h2
`define IPDE_TRAY_3 2'h3
`define IPDE_INIT_ROT_SEC 2
`define IPDE_LAST_ROT_SEC 2
`define IPDE_DOOR_ROT_SEC 2
`endif

// ==== rtl/ipde_sync.v ====
// Purpose: three-stage synchroniser with agreement filter
// Assumes: asynchronous pin input
// Notes: output changes once stages two and three agree
`timescale 1ns/1ps
module ipde_sync (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_async,
  output reg o_level
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  // first stage feeds only the second
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      o_level <= 1'b0;
    end else begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        o_level <= s3_r;
      end
    end
  end
endmodule

// ==== rtl/ipde_open_close.v ====
// Purpose: detect an open-then-close cycle on a closed/open sensor
// Assumes: i_open already synchronised, high while open
// Notes: one-cycle pulse on the closing edge after an opening
`timescale 1ns/1ps
module ipde_open_close (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_open,
  output wire o_cycled
);
  reg seen_open_r;
  // pulse only when an opening was seen first
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seen_open_r <= 1'b0;
    end else if (i_open) begin
      seen_open_r <= 1'b1;
    end else begin
      seen_open_r <= 1'b0;
    end
  end
  assign o_cycled = seen_open_r & ~i_open;
endmodule

// ==== rtl/ipde_top.v ====
// Purpose: idle power-down control and engine motor sequencing
// Assumes: host traffic and settings arrive synchronous; pins are async
// Notes: fonts and macros live elsewhere; this block never clears them
`timescale 1ns/1ps
`include "ipde_regs.vh"
module ipde_top #(
  parameter [37:0] MIN_CYCLES = 38'd3000000000,
  parameter [31:0] INIT_ROT_CYCLES = `IPDE_INIT_ROT_SEC * `IPDE_CLK_HZ,
  parameter [31:0] LAST_ROT_CYCLES = `IPDE_LAST_ROT_SEC * `IPDE_CLK_HZ,
  parameter [31:0] DOOR_ROT_CYCLES = `IPDE_DOOR_ROT_SEC * `IPDE_CLK_HZ
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_defaults_restore,
  input wire i_panel_pd_enable,
  input wire i_panel_pd_enable_we,
  input wire [2:0] i_panel_timeout_sel,
  input wire i_panel_timeout_we,
  input wire i_host_activity,
  input wire i_panel_key,
  input wire [3:0] i_door_open,
  input wire i_front_door_open,
  input wire [4:0] i_tray_open,
  input wire i_self_test_sw,
  input wire i_error_active,
  input wire i_fuser_cool,
  input wire i_panel_smooth,
  input wire i_panel_smooth_we,
  input wire i_host_smooth,
  input wire i_host_smooth_we,
  input wire i_panel_toner_save,
  input wire i_panel_toner_save_we,
  input wire i_print_request,
  input wire [1:0] i_job_tray,
  input wire i_paper_synced,
  input wire i_page_done,
  input wire i_formatter_video,
  output reg o_idle_power_down,
  output reg o_show_pd_msg,
  output reg o_show_error,
  output reg o_fuser_on,
  output reg o_fans_on,
  output reg o_warm_up,
  output reg o_edge_smoothing,
  output reg o_toner_saving_mode,
  output reg o_video_request,
  output reg o_laser_video,
  output reg o_main_drive_motor,
  output reg o_scanner_motor,
  output reg o_shared_pickup_motor_on,
  output reg o_shared_pickup_motor_rev,
  output reg o_self_test_active
);
  localparam [4:0] ST_INIT = 5'h01;
  localparam [4:0] ST_READY = 5'h02;
  localparam [4:0] ST_SYNC = 5'h04;
  localparam [4:0] ST_PRINT = 5'h08;
  localparam [4:0] ST_LAST = 5'h10;

  wire [3:0] door_s;
  wire [4:0] tray_s;
  wire [3:0] door_cyc;
  wire [4:0] tray_cyc;
  wire front_s;
  wire front_cyc;
  wire test_s;
  reg test_d_r;
  wire test_press;
  wire wake;
  reg pd_en_r;
  reg [2:0] to_sel_r;
  reg [39:0] idle_cnt_r;
  reg [39:0] limit;
  reg [31:0] rot_cnt_r;
  reg [31:0] door_cnt_r;
  reg [4:0] state_r;
  reg [4:0] state_nxt;
  reg [31:0] rot_nxt;
  reg host_smooth_set_r;
  reg line_r;
  reg [1:0] tray_r;

  // pin inputs pass the three-stage filter; one generate pass per door and tray sensor
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_door
      ipde_sync u_s (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_async(i_door_open[gi]),
        .o_level(door_s[gi]));
      ipde_open_close u_c (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_open(door_s[gi]),
        .o_cycled(door_cyc[gi]));
    end
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_tray
      ipde_sync u_s (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_async(i_tray_open[gi]),
        .o_level(tray_s[gi]));
      ipde_open_close u_c (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_open(tray_s[gi]),
        .o_cycled(tray_cyc[gi]));
    end
  endgenerate

  ipde_sync u_front_s (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_async(i_front_door_open),
    .o_level(front_s));
  ipde_open_close u_front_c (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_open(front_s),
    .o_cycled(front_cyc));
  ipde_sync u_test_s (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_async(i_self_test_sw),
    .o_level(test_s));

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      test_d_r <= 1'b0;
    end else begin
      test_d_r <= test_s;
    end
  end
  assign test_press = test_s & ~test_d_r;

  // front door is left out of the wake sources on purpose
  assign wake = i_host_activity
    | i_panel_key
    | (|door_cyc)
    | (|tray_cyc)
    | test_press;

  // power-down settings; panel write may disable entirely
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pd_en_r <= 1'b1;
      to_sel_r <= `IPDE_TO_DEFAULT;
    end else if (i_defaults_restore) begin
      pd_en_r <= 1'b1;
      to_sel_r <= `IPDE_TO_DEFAULT;
    end else begin
      if (i_panel_pd_enable_we) begin
        pd_en_r <= i_panel_pd_enable;
      end
      if (i_panel_timeout_we && i_panel_timeout_sel <= `IPDE_TO_3H) begin
        to_sel_r <= i_panel_timeout_sel;
      end
    end
  end

  // idle limit in cycles; 40 bits since two or three hours overflow 38
  always @* begin
    case (to_sel_r)
      `IPDE_TO_15M: limit = {2'h0, MIN_CYCLES} * `IPDE_MINUTES_15;
      `IPDE_TO_30M: limit = {2'h0, MIN_CYCLES} * `IPDE_MINUTES_30;
      `IPDE_TO_2H: limit = {2'h0, MIN_CYCLES} * `IPDE_MINUTES_120;
      `IPDE_TO_3H: limit = {2'h0, MIN_CYCLES} * `IPDE_MINUTES_180;
      default: limit = {2'h0, MIN_CYCLES} * `IPDE_MINUTES_60;
    endcase
  end

  // idle timer; any wake source or print work restarts it
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idle_cnt_r <= 40'h0;
      o_idle_power_down <= 1'b0;
      o_warm_up <= 1'b0;
    end else begin
      o_warm_up <= 1'b0;
      if (wake || state_r != ST_READY || i_print_request) begin
        idle_cnt_r <= 40'h0;
        if (o_idle_power_down) begin
          o_idle_power_down <= 1'b0;
          o_warm_up <= 1'b1;
        end
      end else if (!pd_en_r) begin
        idle_cnt_r <= 40'h0;
        o_idle_power_down <= 1'b0;
      end else if (!o_idle_power_down) begin
        if (idle_cnt_r >= limit - 40'h1) begin
          o_idle_power_down <= 1'b1;
        end else begin
          idle_cnt_r <= idle_cnt_r + 40'h1;
        end
      end
    end
  end

  // error message outranks the power-down message
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_show_error <= 1'b0;
      o_show_pd_msg <= 1'b0;
    end else begin
      o_show_error <= i_error_active;
      o_show_pd_msg <= o_idle_power_down & ~i_error_active;
    end
  end

  // fuser drops at once, fans wait for fuser to cool
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fuser_on <= 1'b1;
      o_fans_on <= 1'b1;
    end else begin
      o_fuser_on <= ~o_idle_power_down;
      if (state_r == ST_SYNC || state_r == ST_PRINT) begin
        o_fans_on <= 1'b1;
      end else if (o_idle_power_down) begin
        o_fans_on <= ~i_fuser_cool;
      end else begin
        o_fans_on <= 1'b1;
      end
    end
  end

  // image settings; host write sticks over later panel writes
  // settings are never cleared by power-down, only by restore
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_edge_smoothing <= 1'b1;
      o_toner_saving_mode <= 1'b0;
      host_smooth_set_r <= 1'b0;
    end else if (i_defaults_restore) begin
      o_edge_smoothing <= 1'b1;
      o_toner_saving_mode <= 1'b0;
      host_smooth_set_r <= 1'b0;
    end else begin
      if (i_host_smooth_we) begin
        o_edge_smoothing <= i_host_smooth;
        host_smooth_set_r <= 1'b1;
      end else if (i_panel_smooth_we && !host_smooth_set_r) begin
        o_edge_smoothing <= i_panel_smooth;
      end
      if (i_panel_toner_save_we) begin
        o_toner_saving_mode <= i_panel_toner_save;
      end
    end
  end

  // print period sequencer; self-test runs without formatter
  always @* begin
    state_nxt = state_r;
    rot_nxt = rot_cnt_r;
    case (state_r)
      ST_INIT: begin
        if (rot_cnt_r >= INIT_ROT_CYCLES - 32'h1) begin
          state_nxt = ST_READY;
          rot_nxt = 32'h0;
        end else begin
          rot_nxt = rot_cnt_r + 32'h1;
        end
      end
      ST_READY: begin
        if (test_s || (i_print_request && !o_idle_power_down)) begin
          state_nxt = ST_SYNC;
        end
      end
      ST_SYNC: begin
        if (i_paper_synced) begin
          state_nxt = ST_PRINT;
        end
      end
      ST_PRINT: begin
        if (i_page_done) begin
          state_nxt = ST_LAST;
          rot_nxt = 32'h0;
        end
      end
      ST_LAST: begin
        if (test_s) begin
          state_nxt = ST_SYNC;
        end else if (rot_cnt_r >= LAST_ROT_CYCLES - 32'h1) begin
          state_nxt = ST_READY;
        end else begin
          rot_nxt = rot_cnt_r + 32'h1;
        end
      end
      default: begin
        state_nxt = ST_INIT;
        rot_nxt = 32'h0;
      end
    endcase
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_INIT;
      rot_cnt_r <= 32'h0;
      o_self_test_active <= 1'b0;
      tray_r <= `IPDE_TRAY_2;
    end else begin
      state_r <= state_nxt;
      rot_cnt_r <= rot_nxt;
      if (state_r != ST_SYNC && state_nxt == ST_SYNC) begin
        o_self_test_active <= test_s;
        tray_r <= test_s ? `IPDE_TRAY_3 : i_job_tray;
      end else if (state_nxt == ST_READY) begin
        o_self_test_active <= 1'b0;
      end
    end
  end

  // front door cycle spins the main motor for a while
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      door_cnt_r <= 32'h0;
    end else if (front_cyc) begin
      door_cnt_r <= DOOR_ROT_CYCLES;
    end else if (door_cnt_r != 32'h0) begin
      door_cnt_r <= door_cnt_r - 32'h1;
    end
  end

  // motors and video handshake; toggling line pattern for self-test
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_main_drive_motor <= 1'b0;
      o_scanner_motor <= 1'b0;
      o_video_request <= 1'b0;
      o_laser_video <= 1'b0;
      o_shared_pickup_motor_on <= 1'b0;
      o_shared_pickup_motor_rev <= 1'b0;
      line_r <= 1'b0;
    end else begin
      o_main_drive_motor <= (state_r == ST_INIT) | (state_r == ST_SYNC)
        | (state_r == ST_PRINT) | (state_r == ST_LAST) | (door_cnt_r != 32'h0);
      o_scanner_motor <= (state_r == ST_INIT) | (state_r == ST_SYNC)
        | (state_r == ST_PRINT);
      o_video_request <= (state_r == ST_PRINT) & ~o_self_test_active;
      line_r <= ~line_r;
      if (state_r == ST_PRINT) begin
        o_laser_video <= o_self_test_active ? line_r : i_formatter_video;
      end else begin
        o_laser_video <= 1'b0;
      end
      o_shared_pickup_motor_on <= (state_r == ST_SYNC)
        & ((tray_r == `IPDE_TRAY_2) | (tray_r == `IPDE_TRAY_3));
      o_shared_pickup_motor_rev <= (state_r == ST_SYNC) & (tray_r == `IPDE_TRAY_3);
    end
  end
endmodule

// ==== test/ipde_engine_model.sv ====
// Purpose: engine-side stand-in for fuser, paper path and page timing
// Assumes: driven from the block's fuser and pickup outputs
// Notes: i_slow stretches every delay so waiting logic is exercised
`timescale 1ns/1ps
module ipde_engine_model (
  input logic i_clk,
  input logic i_rst_n,
  input logic i_slow,
  input logic i_fuser_on,
  input logic i_pickup_on,
  output logic o_fuser_cool,
  output logic o_paper_synced,
  output logic o_page_done
);
  logic [4:0] cool_cnt, sync_cnt, page_cnt;
  // cool and sync counters saturate so a long idle never wraps back to hot
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cool_cnt <= 5'h00;
      sync_cnt <= 5'h00;
      page_cnt <= 5'h00;
      o_fuser_cool <= 1'b0;
      o_paper_synced <= 1'b0;
      o_page_done <= 1'b0;
    end else begin
      cool_cnt <= i_fuser_on ? 5'h00 : cool_cnt + {4'h0, cool_cnt != 5'h1F};
      o_fuser_cool <= !i_fuser_on && cool_cnt >= (i_slow ? 5'h14 : 5'h04);
      sync_cnt <= i_pickup_on ? sync_cnt + {4'h0, sync_cnt != 5'h1F} : 5'h00;
      // paper reaches registration, then holds until the page ends
      o_paper_synced <= (o_paper_synced && !o_page_done) ||
        sync_cnt == (i_slow ? 5'h09 : 5'h03);
      page_cnt <= o_paper_synced ? page_cnt + 5'h01 : 5'h00;
      o_page_done <= o_paper_synced && page_cnt == (i_slow ? 5'h0E : 5'h06);
    end
  end
endmodule

// ==== test/ipde_top_asserts.sv ====
// Purpose: port-level checks for the idle power-down block
// Assumes: one clock domain, async active-low reset
// Notes: bound onto every ipde_top by port names
`timescale 1ns/1ps
module ipde_top_asserts (
  input logic i_clk,
  input logic i_rst_n,
  input logic i_defaults_restore,
  input logic i_host_activity,
  input logic i_fuser_cool,
  input logic [1:0] i_job_tray,
  input logic i_paper_synced,
  input logic o_idle_power_down,
  input logic o_show_pd_msg,
  input logic o_show_error,
  input logic o_fuser_on,
  input logic o_fans_on,
  input logic o_warm_up,
  input logic o_edge_smoothing,
  input logic o_toner_saving_mode,
  input logic o_video_request,
  input logic o_laser_video,
  input logic o_main_drive_motor,
  input logic o_scanner_motor,
  input logic o_shared_pickup_motor_on,
  input logic o_shared_pickup_motor_rev,
  input logic o_self_test_active
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_fuser_off; $rose(o_idle_power_down) |=> !o_fuser_on; endproperty
  a_fuser_off: assert property (p_fuser_off) else $error("fuser on in power-down");
  property p_wake; o_idle_power_down && i_host_activity |=> o_warm_up && !o_idle_power_down;
  endproperty
  a_wake: assert property (p_wake) else $error("host traffic did not wake");
  property p_err; o_show_error |-> !o_show_pd_msg; endproperty
  a_err: assert property (p_err) else $error("power-down message over error");
  property p_restore; $past(i_defaults_restore) |-> o_edge_smoothing && !o_toner_saving_mode;
  endproperty
  a_restore: assert property (p_restore) else $error("defaults wrong");
  property p_scan; o_scanner_motor |-> o_main_drive_motor; endproperty
  a_scan: assert property (p_scan) else $error("scanner without main motor");
  property p_vid; $rose(o_video_request) |-> $past(i_paper_synced); endproperty
  a_vid: assert property (p_vid) else $error("video before paper sync");
  property p_fans; o_video_request |-> o_fans_on; endproperty
  a_fans: assert property (p_fans) else $error("fans off while printing");
  property p_cool;
    o_idle_power_down && $past(o_idle_power_down) && $past(i_fuser_cool) |-> !o_fans_on;
  endproperty
  a_cool: assert property (p_cool) else $error("fans on after cool down");
  property p_dir;
    o_shared_pickup_motor_on && !o_self_test_active |->
      o_shared_pickup_motor_rev == (i_job_tray == 2'h3);
  endproperty
  a_dir: assert property (p_dir) else $error("pickup direction wrong");
  property p_st_tray; o_self_test_active && o_shared_pickup_motor_on |->
    o_shared_pickup_motor_rev; endproperty
  a_st_tray: assert property (p_st_tray) else $error("self-test not tray three");
  property p_st_vid; o_self_test_active |-> !o_video_request; endproperty
  a_st_vid: assert property (p_st_vid) else $error("self-test asked for video");
  property p_st_line; o_self_test_active && o_laser_video |=> !o_laser_video; endproperty
  a_st_line: assert property (p_st_line) else $error("self-test line not toggling");
  c_line: cover property (o_self_test_active && o_laser_video);
  c_pd: cover property ($rose(o_idle_power_down));
  c_wake: cover property (o_warm_up);
  c_print: cover property (o_video_request);
  c_self: cover property (o_self_test_active);
endmodule
bind ipde_top ipde_top_asserts chk (.*);

// ==== test/test_ipde_top.sv ====
// Purpose: self-checking bench for ipde_top
// Assumes: minute and rotation counts shortened by parameter
// Notes: power-down entries and exits are checked through a queue
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module test_ipde_top;
  localparam int MINC = 10;
  logic i_clk = 0, i_rst_n = 0, i_panel_pd_enable = 1, i_self_test_sw = 0;
  logic i_front_door_open = 0, i_error_active = 0, i_panel_smooth = 0, i_host_smooth = 0;
  logic i_panel_toner_save = 0, i_print_request = 0, i_formatter_video = 0, slow = 0;
  logic [2:0] i_panel_timeout_sel = 0;
  logic [3:0] i_door_open = 0;
  logic [4:0] i_tray_open = 0;
  logic [1:0] i_job_tray = 2'h2, e, vh;
  logic [7:0] stb = 0;
  wire i_panel_pd_enable_we, i_panel_timeout_we, i_panel_toner_save_we, i_host_smooth_we;
  wire i_panel_smooth_we, i_defaults_restore, i_panel_key, i_host_activity;
  wire i_fuser_cool, i_paper_synced, i_page_done;
  wire o_idle_power_down, o_show_pd_msg, o_show_error, o_fuser_on, o_fans_on, o_warm_up;
  wire o_edge_smoothing, o_toner_saving_mode, o_video_request, o_laser_video;
  wire o_main_drive_motor, o_scanner_motor, o_shared_pickup_motor_on;
  wire o_shared_pickup_motor_rev, o_self_test_active;
  int err_total = 0, tests_run = 0, n, b;
  int mins[5] = '{15, 30, 60, 120, 180};
  logic [1:0] expq[$];
  logic pd_q = 0;
  assign {i_panel_pd_enable_we, i_panel_timeout_we, i_panel_toner_save_we, i_host_smooth_we,
    i_panel_smooth_we, i_defaults_restore, i_panel_key, i_host_activity} = stb;
  always #10 i_clk = ~i_clk;
  ipde_top #(.MIN_CYCLES(38'd10), .INIT_ROT_CYCLES(32'd8), .LAST_ROT_CYCLES(32'd8),
    .DOOR_ROT_CYCLES(32'd8)) dut (.*);
  ipde_engine_model eng (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_slow(slow),
    .i_fuser_on(o_fuser_on), .i_pickup_on(o_shared_pickup_motor_on),
    .o_fuser_cool(i_fuser_cool), .o_paper_synced(i_paper_synced), .o_page_done(i_page_done));
  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
  endtask
  task automatic results;
    if (err_total == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // one-cycle strobe; the gap cycle keeps back-to-back strobes apart
  task automatic pulse(input int k);
    stb[k] <= 1'b1;
    cyc(1);
    stb[k] <= 1'b0;
    cyc(1);
  endtask
  // each entry or exit of power-down takes the oldest note off the queue
  always @(posedge i_clk) begin
    if (i_rst_n && o_idle_power_down !== pd_q) begin
      e = expq.size() ? expq.pop_front() : 2'h3;
      `CHK("pd_edge", e, {o_idle_power_down, o_warm_up})
    end
    pd_q <= o_idle_power_down;
  end
  task automatic wake(input int k);
    b = $urandom % 4;
    expq.push_back(2'h1);
    case (k)
      0: pulse(0);
      1: pulse(1);
      2: i_door_open[b] <= 1'b1;
      3: i_tray_open[$urandom % 5] <= 1'b1;
      default: i_self_test_sw <= 1'b1;
    endcase
    cyc(6);
    i_door_open <= 4'h0;
    i_tray_open <= 5'h00;
    i_self_test_sw <= 1'b0;
    n = 0;
    while (o_idle_power_down !== 1'b0 && n < 30) begin
      cyc(1);
      n++;
    end
    `CHK("woke", 1'b0, o_idle_power_down)
  endtask
  // timer is measured from the moment the engine falls quiet again
  task automatic sleep(input int lim);
    n = 0;
    while (o_main_drive_motor !== 1'b0 && n < 200) begin
      cyc(1);
      n++;
    end
    expq.push_back(2'h2);
    n = 0;
    while (o_idle_power_down !== 1'b1 && n < lim + 20) begin
      cyc(1);
      n++;
    end
    `CHK("idle_time", 1'b1, n >= lim - 10 && n <= lim + 3)
    cyc(2);
    `CHK("fuser", 1'b0, o_fuser_on)
    `CHK("pd_msg_on", !i_error_active, o_show_pd_msg)
    `CHK("fans_hot", 1'b1, o_fans_on)
    cyc(40);
    `CHK("fans_cool", 1'b0, o_fans_on)
  endtask
  initial begin
    void'($urandom(32'hc3dc));
    cyc(6);
    i_rst_n <= 1'b1;
    pulse(2);
    `CHK("smooth_def", 1'b1, o_edge_smoothing)
    `CHK("toner_def", 1'b0, o_toner_saving_mode)
    pulse(3);
    `CHK("smooth_panel", 1'b0, o_edge_smoothing)
    i_panel_smooth <= 1'b1;
    pulse(3);
    `CHK("smooth_panel1", 1'b1, o_edge_smoothing)
    i_panel_smooth <= 1'b0;
    i_host_smooth <= 1'b1;
    pulse(4);
    pulse(3);
    `CHK("smooth_host", 1'b1, o_edge_smoothing)
    i_panel_toner_save <= 1'b1;
    pulse(5);
    `CHK("toner_set", 1'b1, o_toner_saving_mode)
    sleep(60 * MINC);
    for (int k = 0; k < 5; k++) begin
      slow <= k[0];
      wake(k);
      i_panel_timeout_sel <= k[2:0];
      pulse(6);
      i_error_active <= (k == 2);
      sleep(mins[k] * MINC);
      if (k == 2) begin
        `CHK("err_shown", 1'b1, o_show_error)
        `CHK("pd_msg", 1'b0, o_show_pd_msg)
      end
      i_error_active <= 1'b0;
    end
    i_front_door_open <= 1'b1;
    cyc(6);
    i_front_door_open <= 1'b0;
    cyc(8);
    `CHK("door_main", 1'b1, o_main_drive_motor)
    `CHK("door_scan", 1'b0, o_scanner_motor)
    cyc(12);
    `CHK("front_door", 1'b1, o_idle_power_down)
    wake(0);
    for (int j = 0; j < 2; j++) begin
      slow <= j[0];
      i_job_tray <= j ? 2'h3 : 2'h2;
      i_print_request <= 1'b1;
      n = 0;
      while (o_video_request !== 1'b1 && n < 80) begin
        cyc(1);
        n++;
      end
      `CHK("video_req", 1'b1, o_video_request)
      i_print_request <= 1'b0;
      // laser shows the dot driven two edges back while video is asked
      vh = {2{i_formatter_video}};
      while (o_video_request === 1'b1 && n < 120) begin
        `CHK("laser", vh[1], o_laser_video)
        vh = {vh[0], 1'($urandom)};
        i_formatter_video <= vh[0];
        cyc(1);
        n++;
      end
      cyc(1);
      `CHK("main_last", 1'b1, o_main_drive_motor)
      `CHK("scan_last", 1'b0, o_scanner_motor)
      cyc(30);
    end
    i_self_test_sw <= 1'b1;
    cyc(100);
    `CHK("self_test", 1'b1, o_self_test_active)
    i_self_test_sw <= 1'b0;
    cyc(120);
    i_panel_timeout_sel <= 3'h0;
    pulse(6);
    i_panel_pd_enable <= 1'b0;
    pulse(7);
    cyc(300);
    `CHK("pd_off", 1'b0, o_idle_power_down)
    `CHK("kept_toner", 1'b1, o_toner_saving_mode)
    `CHK("kept_smooth", 1'b1, o_edge_smoothing)
    results;
  end
  initial begin
    cyc(20000);
    err_total++;
    results;
  end
endmodule
